//--- hdl/uiif_regs.svh
// Register offsets, field positions and timing constants of the iso IN flush timer.
// What this block does
// (R1) A power-on reset clears every field of the pipe timing control register to zero.
// (R2) One timing setting is kept for each of pipes 1 to 9, reached through the pipe select.
// (R3) Bit 12 is the read/write flush enable, 1 allowing the automatic flush of an iso IN pipe.
// (R4) Bits 2 to 0 are the read/write interval field that sets the detection period in frames.
// (R5) Bits 15 to 13 and 11 to 3 read as zero and software writes zero to them.
// (R6) In function mode with flush enabled, an iso IN pipe is flushed when no IN token comes in time.
// (R7) With double buffering on, the flush clears only the plane filled earlier.
// (R8) The flush happens at the SOF that follows the frame in which the token was expected.
// (R9) A corrupted SOF still gives a flush at the expected time, from internal frame interpolation.
// (R10) Software keeps flush enable at zero in host controller mode.
// (R11) Software keeps flush enable at zero for a pipe that is not isochronous.
// (R12) Interval value n means an expected token period of 2 to the n frames since the last token.
`ifndef UIIF_REGS_SVH
`define UIIF_REGS_SVH
`define UIIF_ADDR_SEL 12'h000
`define UIIF_ADDR_TIMING 12'h004
`define UIIF_ADDR_CFG 12'h008
`define UIIF_ADDR_ERR 12'h00c
`define UIIF_SEL_PIPE_MSB 3
`define UIIF_SEL_FUNC_BIT 15
`define UIIF_TIM_FLUSH_BIT 12
`define UIIF_TIM_ITV_MSB 2
`define UIIF_CFG_ISO_BIT 0
`define UIIF_CFG_DBL_BIT 1
`define UIIF_ERR_MSB 9
`define UIIF_ERR_LSB 1
`define UIIF_PIPE_FIRST 4'h1
`define UIIF_PIPE_LAST 4'h9
`define UIIF_CLK_NS 40
`define UIIF_FS_FRAME_NS 1000000
`define UIIF_HS_FRAME_NS 125000
`endif

//--- hdl/uiif_pkg.sv
// Types shared by the iso IN flush timer.
package uiif_pkg;
  typedef struct packed {
    logic [3:0] sel;
    logic func_mode;
    logic [9:1] flush_en;
    logic [9:1][2:0] itv;
    logic [9:1] iso_in;
    logic [9:1] dbl;
    logic [9:1][7:0] cnt;
    logic [9:1] err;
    logic [9:1] flush;
    logic [9:1] flush_both;
    logic [14:0] frm_cnt;
    logic frame_tick;
    logic [31:0] prdata;
    logic slverr;
  } uiif_state_t;
  typedef struct packed {
    logic sof_ok;
    logic hs_mode;
    logic in_token;
    logic [3:0] in_pipe;
    logic [9:1] old_plane;
  } uiif_link_t;
  typedef struct packed {
    logic [9:1] flush;
    logic [9:1] flush_both;
    logic [9:1] flush_plane;
  } uiif_flush_t;
endpackage

//--- hdl/uiif_timer.sv
// APB-reached per-pipe IN interval timer with automatic iso IN buffer flush.
`timescale 1ns/1ps
`include "uiif_regs.svh"
module uiif_timer import uiif_pkg::*; #(
  parameter int unsigned FS_FRAME_CYC = `UIIF_FS_FRAME_NS / `UIIF_CLK_NS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the USB function core.
  input wire uiif_link_t link,
  // Flush requests to the pipe buffers.
  output uiif_flush_t flush
);
  localparam int unsigned HS_FRAME_CYC = `UIIF_HS_FRAME_NS / `UIIF_CLK_NS;
  localparam logic [14:0] FS_LAST = 15'(FS_FRAME_CYC - 1);
  localparam logic [14:0] HS_LAST = 15'(HS_FRAME_CYC - 1);
  // Longest count the frame clock may hold in either speed.
  localparam logic [14:0] MAX_LAST = (FS_LAST > HS_LAST) ? FS_LAST : HS_LAST;

  uiif_state_t s_q;
  uiif_state_t s_d;

  function automatic logic pipe_ok(input logic [3:0] p);
    pipe_ok = (p >= `UIIF_PIPE_FIRST) && (p <= `UIIF_PIPE_LAST);
  endfunction

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `UIIF_ADDR_SEL) || (a == `UIIF_ADDR_TIMING) ||
                 (a == `UIIF_ADDR_CFG) || (a == `UIIF_ADDR_ERR);
  endfunction

  logic wr_en;
  logic rd_setup;
  logic sel_ok;
  assign wr_en = psel & penable & pwrite & known_addr(paddr);
  assign rd_setup = psel & ~penable;
  assign sel_ok = pipe_ok(s_q.sel);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [8:0] nxt;
    logic [7:0] lim;
    logic tok;
    logic [9:1] hit;
    nxt = '0;
    lim = '0;
    tok = 1'b0;
    // Errors raised this cycle; they win over a software clear.
    hit = '0;
    s_d = s_q;
    s_d.flush = '0;
    s_d.flush_both = '0;
    // Interpolated frame clock: a good SOF realigns it, a lost one is replaced.
    s_d.frame_tick = 1'b0;
    if (link.sof_ok) begin
      s_d.frm_cnt = '0;
      s_d.frame_tick = 1'b1; // R8
    end else if (s_q.frm_cnt >= (link.hs_mode ? HS_LAST : FS_LAST)) begin
      // At or past the end, so a switch to the speed with the shorter period wraps at once.
      s_d.frm_cnt = '0;
      s_d.frame_tick = 1'b1; // R9
    end else begin
      s_d.frm_cnt = s_q.frm_cnt + 15'h0001;
    end
    for (int p = int'(`UIIF_PIPE_FIRST); p <= int'(`UIIF_PIPE_LAST); p++) begin
      tok = link.in_token && (link.in_pipe == 4'(p));
      lim = 8'h01 << s_q.itv[p]; // R12
      nxt = {1'b0, s_q.cnt[p]} + 9'h001;
      if (tok) begin
        s_d.cnt[p] = '0; // R12
      end else if (s_q.frame_tick) begin
        if (nxt >= {1'b0, lim}) begin
          s_d.cnt[p] = '0;
          s_d.err[p] = 1'b1;
          hit[p] = 1'b1;
          if (s_q.func_mode && s_q.flush_en[p] && s_q.iso_in[p]) begin
            s_d.flush[p] = 1'b1; // R6
            s_d.flush_both[p] = ~s_q.dbl[p]; // R7
          end
        end else begin
          s_d.cnt[p] = nxt[7:0];
        end
      end
    end
    // Register writes, taken in the access cycle.
    if (wr_en) begin
      unique case (paddr)
        `UIIF_ADDR_SEL: begin
          s_d.sel = pwdata[`UIIF_SEL_PIPE_MSB:0];
          s_d.func_mode = pwdata[`UIIF_SEL_FUNC_BIT];
        end
        `UIIF_ADDR_TIMING: begin
          if (sel_ok) begin
            s_d.flush_en[s_q.sel] = pwdata[`UIIF_TIM_FLUSH_BIT]; // R2 R3
            s_d.itv[s_q.sel] = pwdata[`UIIF_TIM_ITV_MSB:0]; // R4
          end
        end
        `UIIF_ADDR_CFG: begin
          if (sel_ok) begin
            s_d.iso_in[s_q.sel] = pwdata[`UIIF_CFG_ISO_BIT];
            s_d.dbl[s_q.sel] = pwdata[`UIIF_CFG_DBL_BIT];
          end
        end
        `UIIF_ADDR_ERR: begin
          // Write one to clear; a new error in the same cycle stays set.
          s_d.err = (s_q.err & ~pwdata[`UIIF_ERR_MSB:`UIIF_ERR_LSB]) | hit;
        end
      endcase
    end
    // Read data and error are captured in the setup cycle.
    if (rd_setup) begin
      s_d.prdata = '0;
      s_d.slverr = ~known_addr(paddr);
      if (paddr == `UIIF_ADDR_SEL) begin
        s_d.prdata[`UIIF_SEL_PIPE_MSB:0] = s_q.sel;
        s_d.prdata[`UIIF_SEL_FUNC_BIT] = s_q.func_mode;
      end else if (paddr == `UIIF_ADDR_TIMING && sel_ok) begin
        s_d.prdata[`UIIF_TIM_FLUSH_BIT] = s_q.flush_en[s_q.sel]; // R5
        s_d.prdata[`UIIF_TIM_ITV_MSB:0] = s_q.itv[s_q.sel]; // R5
      end else if (paddr == `UIIF_ADDR_CFG && sel_ok) begin
        s_d.prdata[`UIIF_CFG_ISO_BIT] = s_q.iso_in[s_q.sel];
        s_d.prdata[`UIIF_CFG_DBL_BIT] = s_q.dbl[s_q.sel];
      end else if (paddr == `UIIF_ADDR_ERR) begin
        s_d.prdata[`UIIF_ERR_MSB:`UIIF_ERR_LSB] = s_q.err;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0; // R1
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata = s_q.prdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & s_q.slverr;
  assign flush.flush = s_q.flush;
  assign flush.flush_both = s_q.flush_both;
  assign flush.flush_plane = link.old_plane;

  ////////////////////////////////////////////////////////////////////////////
  chk_reset_clear: assert property (@(posedge pclk) $rose(presetn) |-> // R1
    (s_q.flush_en == '0 && s_q.itv == '0)) else $error("timing fields not cleared");
  chk_flush_needs_enable: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (|s_q.flush) |-> $past(s_q.func_mode) &&
    ((s_q.flush & ~$past(s_q.flush_en & s_q.iso_in)) == '0))
    else $error("flush without enable");
  chk_flush_on_tick: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (|s_q.flush) |-> $past(s_q.frame_tick)) else $error("flush off frame boundary");
  chk_dbl_one_plane: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (|s_q.flush) |-> ((s_q.flush_both & $past(s_q.dbl)) == '0))
    else $error("double plane cleared");
  chk_interp_tick: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (!link.sof_ok && !link.hs_mode && s_q.frm_cnt == FS_LAST) |=> s_q.frame_tick)
    else $error("missing interpolated frame");
  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (psel && penable && paddr == `UIIF_ADDR_TIMING) |-> (prdata[15:13] == 3'h0 &&
    prdata[11:3] == 9'h000)) else $error("reserved bits nonzero");
  chk_write_selected: assert property (@(posedge pclk) disable iff (!presetn) // R2 R3 R4
    (wr_en && paddr == `UIIF_ADDR_TIMING && sel_ok) |=>
    (s_q.flush_en[$past(s_q.sel)] == $past(pwdata[`UIIF_TIM_FLUSH_BIT]) &&
    s_q.itv[$past(s_q.sel)] == $past(pwdata[`UIIF_TIM_ITV_MSB:0])))
    else $error("timing write lost");
  chk_token_restart: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (link.in_token && link.in_pipe == 4'h1) |=> (s_q.cnt[1] == 8'h00 && !s_q.flush[1]))
    else $error("token did not restart interval");

  ////////////////////////////////////////////////////////////////////////////
  // Reset clears the link side and the read path as well as the register fields.
  // A second reset in mid-run must leave the same picture as the first.
  chk_reset_idle: assert property (@(posedge pclk) $rose(presetn) |-> // R1
    (s_q.flush == '0 && s_q.err == '0 && s_q.cnt == '0)) else $error("link state not cleared");
  chk_reset_select: assert property (@(posedge pclk) $rose(presetn) |-> // R1
    (s_q.sel == 4'h0 && !s_q.func_mode && s_q.iso_in == '0 && s_q.dbl == '0))
    else $error("pipe setup not cleared");
  chk_reset_read: assert property (@(posedge pclk) $rose(presetn) |-> // R1
    (s_q.prdata == 32'h0000_0000 && !s_q.slverr && s_q.frm_cnt == 15'h0000))
    else $error("read path not cleared");

  // A flush request is a one-cycle strobe; the whole-buffer flag only rides on it.
  chk_flush_strobe: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (|s_q.flush) |=> ((s_q.flush & $past(s_q.flush)) == '0)) else $error("flush held high");
  chk_both_with_flush: assert property (@(posedge pclk) disable iff (!presetn) // R7
    ((s_q.flush_both & ~s_q.flush) == '0)) else $error("whole-buffer flag without flush");
  chk_single_whole: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (|s_q.flush) |-> ((s_q.flush & ~$past(s_q.dbl) & ~s_q.flush_both) == '0))
    else $error("single buffer only partly cleared");
  chk_host_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R6
    $past(!s_q.func_mode) |-> (s_q.flush == '0)) else $error("flush outside function mode");

  // Frame clock: a good SOF realigns it; without one it wraps once a period.
  // Both speeds are watched, and a tick always has a cause.
  chk_sof_realign: assert property (@(posedge pclk) disable iff (!presetn) // R8
    link.sof_ok |=> (s_q.frm_cnt == 15'h0000 && s_q.frame_tick)) else $error("SOF not taken");
  chk_interp_hs: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (!link.sof_ok && link.hs_mode && s_q.frm_cnt == HS_LAST) |=> s_q.frame_tick)
    else $error("missing interpolated microframe");
  chk_fs_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (!link.sof_ok && !link.hs_mode && s_q.frm_cnt == FS_LAST) |=> s_q.frm_cnt == 15'h0000)
    else $error("frame counter did not wrap");
  chk_tick_at_zero: assert property (@(posedge pclk) disable iff (!presetn) // R9
    s_q.frame_tick |-> s_q.frm_cnt == 15'h0000) else $error("frame tick off count start");
  chk_frame_range: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (s_q.frm_cnt <= MAX_LAST)) else $error("frame counter overran");
  chk_tick_cause: assert property (@(posedge pclk) disable iff (!presetn) // R8 R9
    s_q.frame_tick |-> ($past(link.sof_ok) ||
    $past(s_q.frm_cnt) >= ($past(link.hs_mode) ? HS_LAST : FS_LAST)))
    else $error("frame tick without cause");

  // Register bus: zero wait states, unmapped words are refused,
  // and mapped reads show the selected pipe.
  chk_pready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable) |-> pready) else $error("access not answered");
  chk_bus_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |-> (!pready && !pslverr)) else $error("answer without a request");
  chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !known_addr(paddr)) |-> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && known_addr(paddr)) |-> !pslverr)
    else $error("mapped access refused");
  chk_prdata_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  chk_sel_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr == `UIIF_ADDR_SEL) |->
    (prdata[`UIIF_SEL_PIPE_MSB:0] == s_q.sel && prdata[`UIIF_SEL_FUNC_BIT] == s_q.func_mode))
    else $error("select read mismatch");
  chk_timing_no_pipe: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (psel && penable && paddr == `UIIF_ADDR_TIMING && !sel_ok) |-> prdata == 32'h0000_0000)
    else $error("timing read without a pipe");
  chk_cfg_no_pipe: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (psel && penable && paddr == `UIIF_ADDR_CFG && !sel_ok) |-> prdata == 32'h0000_0000)
    else $error("config read without a pipe");
  chk_timing_read: assert property (@(posedge pclk) disable iff (!presetn) // R3 R4
    (psel && penable && paddr == `UIIF_ADDR_TIMING && sel_ok) |->
    (prdata[`UIIF_TIM_FLUSH_BIT] == s_q.flush_en[s_q.sel] &&
    prdata[`UIIF_TIM_ITV_MSB:0] == s_q.itv[s_q.sel])) else $error("timing read mismatch");

  // Writes land in the selected pipe only, and settings never move without a write.
  chk_sel_write: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (wr_en && paddr == `UIIF_ADDR_SEL) |=> (s_q.sel == $past(pwdata[`UIIF_SEL_PIPE_MSB:0]) &&
    s_q.func_mode == $past(pwdata[`UIIF_SEL_FUNC_BIT])))
    else $error("select write lost");
  chk_cfg_write: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (wr_en && paddr == `UIIF_ADDR_CFG && sel_ok) |=>
    (s_q.iso_in[$past(s_q.sel)] == $past(pwdata[`UIIF_CFG_ISO_BIT]) &&
    s_q.dbl[$past(s_q.sel)] == $past(pwdata[`UIIF_CFG_DBL_BIT]))) else $error("config write lost");
  chk_no_sel_write: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (wr_en && paddr == `UIIF_ADDR_TIMING && !sel_ok) |=>
    ($stable(s_q.flush_en) && $stable(s_q.itv))) else $error("write without a pipe landed");
  chk_timing_hold: assert property (@(posedge pclk) disable iff (!presetn) // R3 R4
    !(wr_en && paddr == `UIIF_ADDR_TIMING) |=> ($stable(s_q.flush_en) && $stable(s_q.itv)))
    else $error("timing changed without a write");
  chk_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn) // R2
    !(wr_en && paddr == `UIIF_ADDR_CFG) |=> ($stable(s_q.iso_in) && $stable(s_q.dbl)))
    else $error("config changed without a write");
  chk_sel_hold: assert property (@(posedge pclk) disable iff (!presetn) // R2
    !(wr_en && paddr == `UIIF_ADDR_SEL) |=> ($stable(s_q.sel) && $stable(s_q.func_mode)))
    else $error("select changed without a write");

  // Interval errors stick until software clears them, and each flush logs one.
  chk_err_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (s_q.err[1] && !(wr_en && paddr == `UIIF_ADDR_ERR)) |=> s_q.err[1])
    else $error("interval error lost");
  chk_err_clear: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (wr_en && paddr == `UIIF_ADDR_ERR && pwdata[1] && !s_q.frame_tick) |=>
    !s_q.err[1]) else $error("interval error not cleared");
  chk_err_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (|s_q.flush) |-> ((s_q.flush & ~s_q.err) == '0)) else $error("error not logged with flush");

  ////////////////////////////////////////////////////////////////////////////
  // Per pipe: a token restarts the interval, a flush never comes early,
  // and the plane choice follows the buffering of that pipe.
  for (genvar g = `UIIF_PIPE_FIRST; g <= `UIIF_PIPE_LAST; g++) begin : g_pipe_chk
    chk_pipe_token: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (link.in_token && link.in_pipe == 4'(g)) |=> (s_q.cnt[g] == 8'h00 && !s_q.flush[g]))
      else $error("token did not restart interval");
    chk_pipe_count: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (s_q.cnt[g] < 8'h80)) else $error("interval count overran");
    chk_pipe_restart: assert property (@(posedge pclk) disable iff (!presetn) // R12
      s_q.flush[g] |-> s_q.cnt[g] == 8'h00) else $error("count kept after flush");
    chk_pipe_refused: assert property (@(posedge pclk) disable iff (!presetn) // R6
      s_q.flush[g] |-> $past(s_q.flush_en[g] && s_q.iso_in[g] && s_q.func_mode))
      else $error("flush on a refused pipe");
    chk_pipe_early: assert property (@(posedge pclk) disable iff (!presetn) // R12
      s_q.flush[g] |-> ({1'b0, $past(s_q.cnt[g])} + 9'h001 >= (9'h001 << $past(s_q.itv[g]))))
      else $error("flush before the interval ran out");
    chk_pipe_single: assert property (@(posedge pclk) disable iff (!presetn) // R7
      (s_q.flush[g] && $past(s_q.dbl[g])) |-> !s_q.flush_both[g])
      else $error("both planes cleared");
    chk_pipe_whole: assert property (@(posedge pclk) disable iff (!presetn) // R7
      (s_q.flush[g] && !$past(s_q.dbl[g])) |-> s_q.flush_both[g])
      else $error("single buffer not fully cleared");
  end
endmodule

//--- verification/uiif_host.sv
// Behavioural USB host that sends SOF packets and IN tokens to the flush timer.
`timescale 1ns/1ps
module uiif_host import uiif_pkg::*; #(
  parameter int PER = 50
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Traffic controls; a dropped SOF stands for a corrupted one.
  input wire logic sof_on,
  input wire logic tok_on,
  input wire logic hs_on,
  input wire logic [9:1] plane,
  // Link events.
  output uiif_link_t link
);
  int cyc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc <= 0;
      link <= '0;
    end else begin
      cyc <= (cyc == PER - 1) ? 0 : cyc + 1;
      link.sof_ok <= sof_on && cyc == PER - 1;
      link.in_token <= tok_on && cyc == PER / 2;
      // Outside a token the pipe number toggles, so a stale value is never trusted.
      link.in_pipe <= (tok_on && cyc == PER / 2) ? 4'h1 : ~link.in_pipe;
      link.hs_mode <= hs_on;
      link.old_plane <= plane;
    end
  end
endmodule

//--- verification/usb_iso_in_interval_flush_tb.sv
// Self-checking bench for the iso IN flush timer.
`timescale 1ns/1ps
`include "uiif_regs.svh"
module usb_iso_in_interval_flush_tb import uiif_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ps, sof_on = 1, tok_on = 0;
  logic hs_on = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic pready, pslverr;
  logic [9:1] plane = 0;
  uiif_link_t link;
  uiif_flush_t flush;
  int n_fail = 0, checked = 0, n, seed = 32'h6ff123a6, exp_tim[10];
  uiif_timer #(.FS_FRAME_CYC(50)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link), .flush(flush));
  uiif_host #(.PER(50)) host_u (.pclk(pclk), .presetn(presetn), .sof_on(sof_on),
    .tok_on(tok_on), .hs_on(hs_on), .plane(plane), .link(link));
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    ps = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Measures the spacing of two flushes of pipe 1 and checks the plane choice.
  task automatic gap(input int e);
    while (flush.flush[1] !== 1'b1) @(posedge pclk);
    chk(flush.flush_both[1], 0);
    chk(flush.flush_plane[1], plane[1]);
    n = 1;
    @(posedge pclk);
    while (flush.flush[1] !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    chk(n, e);
  endtask
  task automatic quiet();
    n = 0;
    repeat (300) begin
      @(posedge pclk);
      if (flush.flush[1] !== 1'b0) n++;
    end
    chk(n, 0);
  endtask
  task automatic end_sim();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_fail++;
    end_sim();
  end
  initial begin
    plane = 9'($random(seed));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(flush, 0);
    for (int p = 1; p < 10; p++) begin
      apb(1'b1, `UIIF_ADDR_SEL, 32'h8000 | p);
      apb(1'b0, `UIIF_ADDR_TIMING, 0);
      chk(rd, 0);
      d = $random(seed);
      exp_tim[p] = d & 32'h1007;
      apb(1'b1, `UIIF_ADDR_TIMING, d);
    end
    for (int p = 1; p < 10; p++) begin
      apb(1'b1, `UIIF_ADDR_SEL, 32'h8000 | p);
      apb(1'b0, `UIIF_ADDR_TIMING, 0);
      chk(rd, exp_tim[p]);
    end
    apb(1'b0, 12'h010, 0);
    chk(ps, 1);
    chk(rd, 0);
    // Function mode on pipe 1, which is iso IN with double buffering.
    apb(1'b1, `UIIF_ADDR_SEL, 32'h8001);
    apb(1'b1, `UIIF_ADDR_CFG, 3);
    apb(1'b1, `UIIF_ADDR_TIMING, 32'h1001);
    gap(100);
    sof_on <= 1'b0;
    apb(1'b1, `UIIF_ADDR_TIMING, 32'h1002);
    gap(200);
    sof_on <= 1'b1;
    tok_on <= 1'b1;
    apb(1'b1, `UIIF_ADDR_TIMING, 32'h1001);
    quiet();
    tok_on <= 1'b0;
    apb(1'b1, `UIIF_ADDR_TIMING, 32'h0001);
    quiet();
    // Microframes with no SOF at all: a flush at every interpolated tick.
    sof_on <= 1'b0;
    hs_on <= 1'b1;
    apb(1'b1, `UIIF_ADDR_TIMING, 32'h1000);
    gap(3125);
    apb(1'b0, `UIIF_ADDR_ERR, 0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, `UIIF_ADDR_ERR, 32'h3fe);
    apb(1'b0, `UIIF_ADDR_ERR, 0);
    chk(rd, 0);
    // A second reset in mid-run clears every setting again.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(flush, 0);
    apb(1'b1, `UIIF_ADDR_SEL, 32'h8001);
    apb(1'b0, `UIIF_ADDR_TIMING, 0);
    chk(rd, 0);
    apb(1'b0, `UIIF_ADDR_CFG, 0);
    chk(rd, 0);
    end_sim();
  end
endmodule
